//--- rtl/csc_regs.vh
// Purpose: Constants for the clock synthesizer configuration register block
// Assumes: Registers are reached over the two-wire serial port only
// Notes:   Offsets are register indexes carried in a 16-bit pointer
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

`define CSC_REG_STATUS_IDX   16'h0003
`define CSC_REG_INPUT_IDX    16'h0004
`define CSC_REG_STATUS_RST   16'h0000
`define CSC_REG_INPUT_RST    16'h0000

`define CSC_ST1_REFCLK_BIT   12
`define CSC_ST1_LOSS_BIT     11
`define CSC_ST1_LOCK_BIT     10
`define CSC_ST0_REFCLK_BIT   9
`define CSC_ST0_LOSS_BIT     8
`define CSC_ST0_LOCK_BIT     7
`define CSC_SOFT_RST_BIT     6
`define CSC_SYNC_N_BIT       5
`define CSC_CAL_EN_BIT       4
`define CSC_PS_B_HI          3
`define CSC_PS_B_LO          2
`define CSC_PS_A_HI          1
`define CSC_PS_A_LO          0

`define CSC_SHAPE_HI         15
`define CSC_SHAPE_LO         14
`define CSC_AUTO_MAN_BIT     13
`define CSC_REF_CHOICE_BIT   12
`define CSC_PRI_DIV_HI       11
`define CSC_PRI_DIV_LO       8
`define CSC_SEC_BUF_HI       7
`define CSC_SEC_BUF_LO       6
`define CSC_SEC_EN_BIT       5
`define CSC_PRI_BUF_HI       4
`define CSC_PRI_BUF_LO       3
`define CSC_PRI_EN_BIT       2
`define CSC_SEC_SUP_BIT      1
`define CSC_PRI_SUP_BIT      0

`define CSC_PS_DIV4          2'h0
`define CSC_PS_DIV5          2'h1
`define CSC_PS_DIV6          2'h2
`define CSC_RATIO4           3'h4
`define CSC_RATIO5           3'h5
`define CSC_RATIO6           3'h6
`define CSC_RATIO_RSVD       3'h0

`define CSC_I2C_ADDR_FIXED   5'h15
`define CSC_BITS_PER_BYTE    4'h8
`define CSC_BYTE_SLAVE       3'h0
`define CSC_BYTE_PTR_HI      3'h1
`define CSC_BYTE_PTR_LO      3'h2
`define CSC_BYTE_DATA_HI     3'h3
`define CSC_BYTE_DATA_LO     3'h4
`define CSC_BYTE_EXTRA       3'h5

`endif

//--- rtl/csc_sync2.v
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Each bit is an independent level, not a bus value
// Notes:   Only the second flop is visible outside
`default_nettype none

module csc_sync2 #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

//--- rtl/csc_config_regs.v
// Purpose: Status/prescaler and input mux configuration registers with two-wire slave
// Assumes: SCL far slower than clk; pins pass two flops before use
// Notes:   Open-drain SDA: sda_oe_b low pulls the line low
`include "csc_regs.vh"
`default_nettype none

module csc_config_regs (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_b,
  input  wire       addr_pin1,
  input  wire       addr_pin0,
  input  wire       ref_select_pin,
  input  wire       pll_lock,
  input  wire       ref_loss,
  input  wire       auto_secondary_active,
  output reg        status0_pin,
  output reg        status1_pin,
  output reg        secondary_selected,
  output reg        core_reset_b,
  output reg        divider_sync_n,
  output reg        calibration_enable,
  output reg  [2:0] prescaler_b_ratio,
  output reg  [2:0] prescaler_a_ratio,
  output reg        mux_delay_enable,
  output reg        mux_reshape_enable,
  output reg        input_mux_auto_manual,
  output reg  [4:0] primary_input_divider,
  output reg  [1:0] secondary_buffer_type,
  output reg        secondary_input_enable,
  output reg  [1:0] primary_buffer_type,
  output reg        primary_input_enable,
  output reg        secondary_supply_level,
  output reg        primary_supply_level
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX   = 5'b00010;
  localparam [4:0] ST_ACK  = 5'b00100;
  localparam [4:0] ST_TX   = 5'b01000;
  localparam [4:0] ST_RACK = 5'b10000;

  wire [7:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       refsel_s;
  wire       lock_s;
  wire       loss_s;
  wire       auto_sec_s;
  wire       ad1_s;
  wire       ad0_s;

  csc_sync2 #(
    .WIDTH (8)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({scl_in, sda_in, ref_select_pin, pll_lock, ref_loss,
                auto_secondary_active, addr_pin1, addr_pin0}),
    .sync_out (pins_s)
  );

  assign scl_s      = pins_s[7];
  assign sda_s      = pins_s[6];
  assign refsel_s   = pins_s[5];
  assign lock_s     = pins_s[4];
  assign loss_s     = pins_s[3];
  assign auto_sec_s = pins_s[2];
  assign ad1_s      = pins_s[1];
  assign ad0_s      = pins_s[0];

  reg        scl_q;
  reg        sda_q;
  reg  [4:0] state_q;
  reg  [3:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg  [2:0] byte_idx_q;
  reg        rw_q;
  reg        mst_ack_q;
  reg        tx_lo_q;
  reg [15:0] ptr_q;
  reg  [7:0] wr_hi_q;
  reg [15:0] stat_reg_q;
  reg [15:0] inp_reg_q;
  reg        sda_oe_b_q;

  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [15:0] rd_word;
  wire [7:0]  rd_byte;
  wire        addr_hit;

  // Bus lines only change while SCL low, except start and stop
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  assign rd_word = (ptr_q == `CSC_REG_STATUS_IDX) ? stat_reg_q :
                   (ptr_q == `CSC_REG_INPUT_IDX)  ? inp_reg_q  : 16'h0000;
  assign rd_byte = tx_lo_q ? rd_word[7:0] : rd_word[15:8];

  assign addr_hit = (shift_q[7:1] == {`CSC_I2C_ADDR_FIXED, ad1_s, ad0_s});

  assign sda_out  = 1'b0;
  assign sda_oe_b = sda_oe_b_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      byte_idx_q <= `CSC_BYTE_SLAVE;
      rw_q       <= 1'b0;
      mst_ack_q  <= 1'b0;
      tx_lo_q    <= 1'b0;
      ptr_q      <= 16'h0000;
      wr_hi_q    <= 8'h00;
      stat_reg_q <= `CSC_REG_STATUS_RST;
      inp_reg_q  <= `CSC_REG_INPUT_RST;
      sda_oe_b_q <= 1'b1;
    end else if (bus_start) begin
      // Repeated start keeps the pointer for a read-back
      state_q    <= ST_RX;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= `CSC_BYTE_SLAVE;
      tx_lo_q    <= 1'b0;
      sda_oe_b_q <= 1'b1;
    end else if (bus_stop) begin
      state_q    <= ST_IDLE;
      sda_oe_b_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_oe_b_q <= 1'b1;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `CSC_BITS_PER_BYTE) begin
            bit_cnt_q <= 4'h0;
            if (byte_idx_q == `CSC_BYTE_SLAVE) begin
              if (addr_hit) begin
                rw_q       <= shift_q[0];
                state_q    <= ST_ACK;
                sda_oe_b_q <= 1'b0;
                byte_idx_q <= `CSC_BYTE_PTR_HI;
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (byte_idx_q == `CSC_BYTE_EXTRA) begin
              // Bytes past one word are refused with a nack
              state_q <= ST_IDLE;
            end else begin
              state_q    <= ST_ACK;
              sda_oe_b_q <= 1'b0;
              byte_idx_q <= byte_idx_q + 3'h1;
              if (byte_idx_q == `CSC_BYTE_PTR_HI) begin
                ptr_q[15:8] <= shift_q;
              end else if (byte_idx_q == `CSC_BYTE_PTR_LO) begin
                ptr_q[7:0] <= shift_q;
              end else if (byte_idx_q == `CSC_BYTE_DATA_HI) begin
                wr_hi_q <= shift_q;
              end else if (ptr_q == `CSC_REG_STATUS_IDX) begin
                stat_reg_q <= {wr_hi_q, shift_q};
              end else if (ptr_q == `CSC_REG_INPUT_IDX) begin
                inp_reg_q <= {wr_hi_q, shift_q};
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rw_q && byte_idx_q == `CSC_BYTE_PTR_HI) begin
              state_q    <= ST_TX;
              shift_q    <= rd_byte;
              sda_oe_b_q <= rd_byte[7];
            end else begin
              state_q    <= ST_RX;
              sda_oe_b_q <= 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              state_q    <= ST_RACK;
              sda_oe_b_q <= 1'b1;
              bit_cnt_q  <= 4'h0;
              tx_lo_q    <= ~tx_lo_q;
            end else begin
              shift_q    <= {shift_q[6:0], 1'b0};
              sda_oe_b_q <= shift_q[6];
              bit_cnt_q  <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mst_ack_q <= ~sda_s;
          end else if (scl_fall) begin
            // Master nack ends the read and frees the line
            if (mst_ack_q) begin
              state_q    <= ST_TX;
              shift_q    <= rd_byte;
              sda_oe_b_q <= rd_byte[7];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          sda_oe_b_q <= 1'b1;
        end
      endcase
    end
  end

  function [2:0] ps_ratio;
    input [1:0] code;
    begin
      case (code)
        `CSC_PS_DIV4: ps_ratio = `CSC_RATIO4;
        `CSC_PS_DIV5: ps_ratio = `CSC_RATIO5;
        `CSC_PS_DIV6: ps_ratio = `CSC_RATIO6;
        default:      ps_ratio = `CSC_RATIO_RSVD;
      endcase
    end
  endfunction

  wire manual_mode;
  wire sel_sec_d;
  wire [2:0] ind_d;

  assign manual_mode = inp_reg_q[`CSC_AUTO_MAN_BIT];
  // choice bit ignored in auto mode
  assign sel_sec_d = manual_mode ? (inp_reg_q[`CSC_REF_CHOICE_BIT] & refsel_s)
                                 : auto_sec_s;
  // auto mode relies on host enabling both inputs
  assign ind_d = {sel_sec_d, loss_s, lock_s};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status0_pin            <= 1'b0;
      status1_pin            <= 1'b0;
      secondary_selected     <= 1'b0;
      core_reset_b           <= 1'b0;
      divider_sync_n         <= 1'b0;
      calibration_enable     <= 1'b0;
      prescaler_b_ratio      <= `CSC_RATIO4;
      prescaler_a_ratio      <= `CSC_RATIO4;
      mux_delay_enable       <= 1'b0;
      mux_reshape_enable     <= 1'b0;
      input_mux_auto_manual  <= 1'b0;
      primary_input_divider  <= 5'h01;
      secondary_buffer_type  <= 2'h0;
      secondary_input_enable <= 1'b0;
      primary_buffer_type    <= 2'h0;
      primary_input_enable   <= 1'b0;
      secondary_supply_level <= 1'b0;
      primary_supply_level   <= 1'b0;
    end else begin
      status1_pin <= |(ind_d & stat_reg_q[`CSC_ST1_REFCLK_BIT:`CSC_ST1_LOCK_BIT]);
      status0_pin <= |(ind_d & stat_reg_q[`CSC_ST0_REFCLK_BIT:`CSC_ST0_LOCK_BIT]);
      secondary_selected <= sel_sec_d;
      core_reset_b <= stat_reg_q[`CSC_SOFT_RST_BIT];
      divider_sync_n <= stat_reg_q[`CSC_SYNC_N_BIT];
      calibration_enable <= stat_reg_q[`CSC_CAL_EN_BIT];
      prescaler_b_ratio <= ps_ratio(stat_reg_q[`CSC_PS_B_HI:`CSC_PS_B_LO]);
      prescaler_a_ratio <= ps_ratio(stat_reg_q[`CSC_PS_A_HI:`CSC_PS_A_LO]);
      // delay is low bit, reshape high bit
      mux_delay_enable   <= inp_reg_q[`CSC_SHAPE_LO];
      mux_reshape_enable <= inp_reg_q[`CSC_SHAPE_HI];
      input_mux_auto_manual <= manual_mode;
      primary_input_divider <= {1'b0, inp_reg_q[`CSC_PRI_DIV_HI:`CSC_PRI_DIV_LO]} + 5'h01;
      secondary_buffer_type <= inp_reg_q[`CSC_SEC_BUF_HI:`CSC_SEC_BUF_LO];
      // codes 10 and 11 both LVCMOS
      primary_buffer_type <= inp_reg_q[`CSC_PRI_BUF_HI] ? 2'h2
                             : inp_reg_q[`CSC_PRI_BUF_HI:`CSC_PRI_BUF_LO];
      secondary_input_enable <= inp_reg_q[`CSC_SEC_EN_BIT];
      primary_input_enable   <= inp_reg_q[`CSC_PRI_EN_BIT];
      // supply levels, 0 means 1.8 V
      secondary_supply_level <= inp_reg_q[`CSC_SEC_SUP_BIT];
      primary_supply_level   <= inp_reg_q[`CSC_PRI_SUP_BIT];
    end
  end

endmodule

`default_nettype wire

//--- verif/csc_config_regs_checker.sv
// Purpose: Port-level checks of the config register block
// Assumes: One clock, rst_b async active low
// Notes:   Six-cycle windows cover the two-flop pin sync
`default_nettype none
module csc_config_regs_checker (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       scl_in,
  input wire logic       pll_lock,
  input wire logic       ref_loss,
  input wire logic       ref_select_pin,
  input wire logic       auto_secondary_active,
  input wire logic       sda_out,
  input wire logic       sda_oe_b,
  input wire logic       status0_pin,
  input wire logic       status1_pin,
  input wire logic       secondary_selected,
  input wire logic       input_mux_auto_manual,
  input wire logic       calibration_enable,
  input wire logic       core_reset_b,
  input wire logic [2:0] prescaler_a_ratio,
  input wire logic [2:0] prescaler_b_ratio,
  input wire logic [4:0] primary_input_divider,
  input wire logic [1:0] primary_buffer_type
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_sda_zero: assert property (!sda_out)
    else $error("data value not low");
  a_ratio_a: assert property (prescaler_a_ratio inside {3'h0, 3'h4, 3'h5, 3'h6})
    else $error("prescaler a ratio bad");
  a_ratio_b: assert property (prescaler_b_ratio inside {3'h0, 3'h4, 3'h5, 3'h6})
    else $error("prescaler b ratio bad");
  a_div_range: assert property (primary_input_divider inside {[5'h1:5'h10]})
    else $error("divider out of range");
  a_pri_buf: assert property (primary_buffer_type != 2'h3)
    else $error("primary buffer code 3 seen");
  a_status_quiet: assert property (
    (!pll_lock && !ref_loss && !secondary_selected)[*6] |-> !status0_pin && !status1_pin)
    else $error("status pin without cause");
  a_manual_pin: assert property (
    (input_mux_auto_manual && !ref_select_pin)[*6] |-> !secondary_selected)
    else $error("secondary picked with pin low");
  a_auto_follow: assert property (
    (!input_mux_auto_manual && auto_secondary_active)[*6] |-> secondary_selected)
    else $error("auto choice not followed");
  a_cfg_hold: assert property (scl_in[*6] |=> $stable({core_reset_b,
    calibration_enable, prescaler_a_ratio, primary_input_divider}))
    else $error("config moved without bus activity");
  // Data line only moves while the serial clock is low
  a_sda_scl_low: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_b))
    else $error("data drive changed while clock high");
endmodule
bind csc_config_regs csc_config_regs_checker i_chk (.*);
`default_nettype wire

//--- verif/csc_host_model.sv
// Purpose: Two-wire bus host for the config register block
// Assumes: Pull-up on data, resolved level fed back on sda
// Notes:   Half bits of four clocks or more; data moves after SCL fall
`default_nettype none
module csc_host_model (
  input  wire logic       clk,
  input  wire logic       sda,
  input  wire logic [1:0] ad,
  output var  logic       scl,
  output var  logic       sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic bit_io(input logic o, output logic i);
    tick(1);
    sda_pull = !o;
    tick(3);
    scl = 1'b1;
    tick(3);
    i = sda;
    tick(3);
    scl = 1'b0;
  endtask
  task automatic start();
    tick(1);
    sda_pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int k = 7; k >= 0; k--) bit_io(tx[k], rx[k]);
    bit_io(mack, ack);
  endtask
  task automatic wr(input logic [15:0] idx, d, output logic nak);
    logic [7:0]  r;
    logic        a;
    logic [39:0] s;
    s = {5'h15, ad, 1'b0, idx, d};
    nak = 1'b0;
    start();
    for (int b = 4; b >= 0; b--) begin
      xfer(s[b*8 +: 8], 1'b1, r, a);
      nak = nak | a;
    end
    stop();
  endtask
  task automatic rd(input logic [15:0] idx, output logic [15:0] d, output logic nak);
    logic [7:0]  r;
    logic        a;
    logic [23:0] s;
    s = {5'h15, ad, 1'b0, idx};
    nak = 1'b0;
    start();
    for (int b = 2; b >= 0; b--) begin
      xfer(s[b*8 +: 8], 1'b1, r, a);
      nak = nak | a;
    end
    start();
    xfer({5'h15, ad, 1'b1}, 1'b1, r, a);
    nak = nak | a;
    xfer(8'hff, 1'b0, d[15:8], a);
    xfer(8'hff, 1'b1, d[7:0], a);
    stop();
  endtask
  // sixth byte of a write is refused
  task automatic wr_long(input logic [15:0] idx, d, output logic [5:0] naks);
    logic [7:0]  r;
    logic [47:0] s;
    s = {5'h15, ad, 1'b0, idx, d, 8'h00};
    start();
    for (int b = 5; b >= 0; b--) begin
      xfer(s[b*8 +: 8], 1'b1, r, naks[b]);
    end
    stop();
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the config register block
// Assumes: Host model owns the bus; pins settle in eight clocks
// Notes:   Top bits of the status word are always written as zero
`include "csc_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       rst_b;
  logic       addr_pin1;
  logic       addr_pin0;
  logic       ref_select_pin;
  logic       pll_lock;
  logic       ref_loss;
  logic       auto_secondary_active;
  logic [1:0] host_ad;
  int         errors;
  int         n_compared;
  wire        scl_in, sda_pull, sda_out, sda_oe_b, status0_pin, status1_pin;
  wire        secondary_selected, core_reset_b, divider_sync_n, calibration_enable;
  wire        mux_delay_enable, mux_reshape_enable, input_mux_auto_manual;
  wire        secondary_input_enable, primary_input_enable;
  wire        secondary_supply_level, primary_supply_level;
  wire  [2:0] prescaler_b_ratio, prescaler_a_ratio;
  wire  [4:0] primary_input_divider;
  wire  [1:0] secondary_buffer_type, primary_buffer_type;
  // Open drain with pull-up
  wire        sda_in = !((!sda_oe_b && !sda_out) || sda_pull);
  csc_config_regs i_csc_config_regs (.*);
  csc_host_model i_csc_host_model (
    .clk      (clk),
    .sda      (sda_in),
    .ad       (host_ad),
    .scl      (scl_in),
    .sda_pull (sda_pull)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic [2:0] ratio(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h4 + c;
  endfunction
  task automatic wr_ok(input logic [15:0] idx, v);
    logic n;
    i_csc_host_model.wr(idx, v, n);
    chk(n, 1'b0);
  endtask
  task automatic rd_chk(input logic [15:0] idx, exp);
    logic [15:0] d;
    logic        n;
    i_csc_host_model.rd(idx, d, n);
    chk(n, 1'b0);
    chk(d, exp);
  endtask
  // Pins: lock, loss, select, auto choice
  task automatic set_in(input logic [3:0] p);
    {pll_lock, ref_loss, ref_select_pin, auto_secondary_active} = p;
    repeat (8) @(posedge clk);
    #2;
  endtask
  task automatic t_reset();
    chk(prescaler_a_ratio, 3'h4);
    chk(prescaler_b_ratio, 3'h4);
    chk(primary_input_divider, 5'h1);
    chk(sda_oe_b, 1'b1);
    rd_chk(`CSC_REG_STATUS_IDX, 16'h0000);
    rd_chk(`CSC_REG_INPUT_IDX, 16'h0000);
  endtask
  task automatic t_reg3();
    logic [1:0]  c;
    logic [15:0] v;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      v = {3'h0, 6'h0, c[0], c[1], !c[0], c, ~c};
      wr_ok(`CSC_REG_STATUS_IDX, v);
      chk(prescaler_b_ratio, ratio(c));
      chk(prescaler_a_ratio, ratio(~c));
      chk(core_reset_b, c[0]);
      chk(divider_sync_n, c[1]);
      chk(calibration_enable, !c[0]);
      rd_chk(`CSC_REG_STATUS_IDX, v);
    end
  endtask
  task automatic t_reg4();
    logic [15:0] v;
    // auto words keep both inputs on
    logic [15:0] tbl [4] = '{16'h2008, 16'hffff, 16'h4a3c, 16'h91b6};
    for (int k = 0; k < 4; k++) begin
      v = tbl[k];
      wr_ok(`CSC_REG_INPUT_IDX, v);
      chk({mux_reshape_enable, mux_delay_enable}, v[15:14]);
      chk(input_mux_auto_manual, v[13]);
      chk(primary_input_divider, {1'b0, v[11:8]} + 5'h1);
      chk(secondary_buffer_type, v[7:6]);
      chk(primary_buffer_type, v[4] ? 2'h2 : v[4:3]);
      chk({secondary_input_enable, primary_input_enable}, {v[5], v[2]});
      chk({secondary_supply_level, primary_supply_level}, v[1:0]);
      rd_chk(`CSC_REG_INPUT_IDX, v);
    end
  endtask
  // Compares {status1, status0, secondary selected}
  task automatic t_status();
    wr_ok(`CSC_REG_INPUT_IDX, 16'h3024);
    wr_ok(`CSC_REG_STATUS_IDX, 16'h1560);
    set_in(4'b0010);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b101);
    set_in(4'b0000);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b000);
    set_in(4'b1000);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b100);
    set_in(4'b0100);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b010);
    wr_ok(`CSC_REG_STATUS_IDX, 16'h03e0);
    set_in(4'b1010);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b011);
    wr_ok(`CSC_REG_STATUS_IDX, 16'h1c60);
    set_in(4'b0100);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b100);
    wr_ok(`CSC_REG_STATUS_IDX, 16'h0060);
    set_in(4'b1110);
    chk({status1_pin, status0_pin, secondary_selected}, 3'b001);
    wr_ok(`CSC_REG_INPUT_IDX, 16'h1024);
    set_in(4'b0001);
    chk(secondary_selected, 1'b1);
    set_in(4'b0010);
    chk(secondary_selected, 1'b0);
    wr_ok(`CSC_REG_INPUT_IDX, 16'h2024);
    set_in(4'b0011);
    chk(secondary_selected, 1'b0);
  endtask
  task automatic t_refused();
    logic       n;
    logic [5:0] a6;
    wr_ok(16'h0007, 16'hffff);
    rd_chk(16'h0007, 16'h0000);
    host_ad = 2'b11;
    i_csc_host_model.wr(`CSC_REG_STATUS_IDX, 16'h1fff, n);
    chk(n, 1'b1);
    host_ad = 2'b01;
    rd_chk(`CSC_REG_STATUS_IDX, 16'h0060);
    i_csc_host_model.wr_long(`CSC_REG_STATUS_IDX, 16'h0070, a6);
    chk(a6, 6'h01);
    chk(calibration_enable, 1'b1);
    rd_chk(`CSC_REG_STATUS_IDX, 16'h0070);
  endtask
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    {addr_pin1, addr_pin0} = 2'b01;
    host_ad = 2'b01;
    {pll_lock, ref_loss, ref_select_pin, auto_secondary_active} = 4'h0;
    repeat (6) @(posedge clk);
    #2;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    t_reset();
    t_reg3();
    t_reg4();
    t_status();
    t_refused();
    wrap_up();
  end
endmodule
`default_nettype wire
